// >>> hw/fcr_map.svh
// Constant map for the FIFO command, reset and status block
`ifndef FCR_MAP_SVH
`define FCR_MAP_SVH
`define FCR_OPC_HI        11
`define FCR_OPC_LO        8
`define FCR_OPR_HI        2
`define FCR_OPR_LO        0
`define FCR_OP_RESET      4'h0
`define FCR_OP_SELCFG     4'h1
`define FCR_OP_SAVE_RD    4'h2
`define FCR_OP_SAVE_WR    4'h3
`define FCR_OP_REST_RD    4'h4
`define FCR_OP_REST_WR    4'h5
`define FCR_OP_DMADIR     4'h6
`define FCR_OP_STFMT      4'h7
`define FCR_OP_INC_AB_RD  4'h8
`define FCR_OP_INC_BA_WR  4'h9
`define FCR_OP_CLR_WPE    4'hA
`define FCR_OP_CLR_RPE    4'hB
`define FCR_RS_BA         3'h1
`define FCR_RS_AB         3'h2
`define FCR_RS_BOTH       3'h3
`define FCR_RS_DMA        3'h4
`define FCR_RS_ALL        3'h7
`define FCR_CFG_DEF       16'h0000
`define FCR_CFG4_DEF      16'h6420
`define FCR_CFG4_IDX      3'h4
`define FCR_CFG5_IDX      3'h5
`define FCR_CFG5_PERIPH   10
`define FCR_NCFG          8
`endif

// >>> hw/fcr_pkg.sv
// Types shared by the FIFO command, reset and status block
package fcr_pkg;
  typedef logic [15:0] fcr_word_t;
  typedef enum logic [2:0]
  {
    FCR_IDLE  = 3'b001,
    FCR_BUSY  = 3'b010,
    FCR_DONE  = 3'b100
  } fcr_acc_e;
endpackage

// >>> hw/fcr_cfg_if.sv
// Carrier between the block top and its configuration register store
`timescale 1ns/10ps
interface fcr_cfg_if;
  logic             wr_en;
  logic [2:0]       wr_addr;
  fcr_pkg::fcr_word_t wr_data;
  logic             init;
  logic [2:0]       rd_addr;
  fcr_pkg::fcr_word_t rd_data;
  logic             periph_mode;
  modport ctl (output wr_en, output wr_addr, output wr_data, output init,
               output rd_addr, input rd_data, input periph_mode);
  modport mem (input wr_en, input wr_addr, input wr_data, input init,
               input rd_addr, output rd_data, output periph_mode);
endinterface

// >>> hw/fcr_cfg_mem.sv
// Eight configuration registers with default load and registered read data
`timescale 1ns/10ps
`include "fcr_map.svh"
module fcr_cfg_mem
(
  input  wire logic core_clk_in,
  input  wire logic rst_in,
  input  wire logic ce_in,
  fcr_cfg_if.mem    cfg
);
  fcr_pkg::fcr_word_t regs_reg [`FCR_NCFG];
  fcr_pkg::fcr_word_t rd_reg;

  function automatic fcr_pkg::fcr_word_t def_val(input int idx);
    def_val = (idx == int'(`FCR_CFG4_IDX)) ? `FCR_CFG4_DEF : `FCR_CFG_DEF;
  endfunction

  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      for (int i = 0; i < `FCR_NCFG; i++)
        regs_reg[i] <= def_val(i);
      rd_reg <= `FCR_CFG_DEF;
    end
    else if (ce_in)
    begin
      for (int i = 0; i < `FCR_NCFG; i++)
        if (cfg.init)
          regs_reg[i] <= def_val(i);
        else if (cfg.wr_en && cfg.wr_addr == 3'(i))
          regs_reg[i] <= cfg.wr_data;
      rd_reg <= regs_reg[cfg.rd_addr];
    end
  end

  assign cfg.rd_data     = rd_reg;
  assign cfg.periph_mode = regs_reg[`FCR_CFG5_IDX][`FCR_CFG5_PERIPH];
endmodule

// >>> hw/fcr_top.sv
// Command decoder, reset control and status word for the dual FIFO
// Function
// - Opcode in bits 11:8, operand in bits 2:0, other bits ignored
// - Opcode 0 resets by operand scope; operands 0, 5, 6 do nothing
// - Opcode 1 sets the configuration register pointer
// - Select operand maps directly onto registers 0 to 7
// - Opcodes 2 and 4 save and restore the reread pointer
// - Opcodes 3 and 5 save and restore the rewrite pointer
// - Opcode 6 sets DMA direction from bit 0, peripheral mode only
// - Opcode 7 picks status format from operand bit 0
// - Opcodes 8 and 9 step read or write pointer by one byte
// - Opcodes 10 and 11 clear write and read parity errors
// - Parity errors stay set until their clear command
// - Operand 1 clears peripheral-to-host pointers and valid; 3 does both FIFOs
// - Operand 2 clears host-to-peripheral pointers only
// - Operand 4 resets only the DMA request circuitry
// - Operand 7 clears pointers, valid, DMA request, reloads config defaults
// - Hardware reset loads all defaults, format 0, direction write
// - Status read and command write at select low, both address lines high
// - Status low byte: odd byte in format 0, flags and direction in format 1
// - Status high byte is common to both formats
`timescale 1ns/10ps
`include "fcr_map.svh"
module fcr_top
#(
  parameter int PTR_W = 10
)
(
  input  wire logic        core_clk_in,
  input  wire logic        rst_in,
  input  wire logic        ce_in,
  input  wire logic        host_chip_select_n_in,
  input  wire logic        host_addr_hi_in,
  input  wire logic        host_addr_lo_in,
  input  wire logic        host_rnw_in,
  input  wire logic        host_data_strobe_n_in,
  input  wire logic [15:0] host_wdata_in,
  input  wire logic [7:0]  odd_byte_in,
  input  wire logic        ab_empty_in,
  input  wire logic        ab_aempty_in,
  input  wire logic        ab_afull_in,
  input  wire logic        ab_full_in,
  input  wire logic        ba_empty_in,
  input  wire logic        ba_aempty_in,
  input  wire logic        ba_afull_in,
  input  wire logic        ba_full_in,
  input  wire logic        wr_parity_err_in,
  input  wire logic        rd_parity_err_in,
  input  wire logic        odd_valid_set_in,
  input  wire logic        odd_valid_clr_in,
  input  wire logic        ab_rd_step_in,
  input  wire logic        ba_wr_step_in,
  output logic      [15:0] host_rdata_out,
  output logic      [15:0] cfg_rdata_out,
  output logic      [2:0]  cfg_sel_out,
  output logic [PTR_W-1:0] ab_rd_ptr_out,
  output logic [PTR_W-1:0] ba_wr_ptr_out,
  output logic             dma_dir_out,
  output logic             dma_req_clr_out,
  output logic             stat_fmt_out,
  output logic             odd_valid_out
);
  if (PTR_W < 2 || PTR_W > 16)
  begin : g_ptr_w_check
    $error("PTR_W out of range");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Host select, address and data synchronisers

  // These pins are only trusted where the last two stages agree; the host
  // holds them steady long before the strobe falls, so agreement costs nothing
  logic [2:0]  cs_sync_reg;
  logic [2:0]  a1_sync_reg;
  logic [2:0]  a0_sync_reg;
  logic [2:0]  rnw_sync_reg;
  logic [15:0] wd_s0_reg;
  logic [15:0] wd_s1_reg;
  logic [15:0] wd_s2_reg;

  wire cs_ok   = (cs_sync_reg[1] == cs_sync_reg[2]);
  wire a1_ok   = (a1_sync_reg[1] == a1_sync_reg[2]);
  wire a0_ok   = (a0_sync_reg[1] == a0_sync_reg[2]);
  wire rnw_ok  = (rnw_sync_reg[1] == rnw_sync_reg[2]);
  wire wd_ok   = (wd_s1_reg == wd_s2_reg);
  wire pins_ok = cs_ok && a1_ok && a0_ok && rnw_ok && wd_ok;

  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      cs_sync_reg  <= 3'h7;
      a1_sync_reg  <= 3'h0;
      a0_sync_reg  <= 3'h0;
      rnw_sync_reg <= 3'h7;
      wd_s0_reg    <= 16'h0000;
      wd_s1_reg    <= 16'h0000;
      wd_s2_reg    <= 16'h0000;
    end
    else if (ce_in)
    begin
      cs_sync_reg  <= {cs_sync_reg[1:0], host_chip_select_n_in};
      a1_sync_reg  <= {a1_sync_reg[1:0], host_addr_hi_in};
      a0_sync_reg  <= {a0_sync_reg[1:0], host_addr_lo_in};
      rnw_sync_reg <= {rnw_sync_reg[1:0], host_rnw_in};
      wd_s0_reg    <= host_wdata_in;
      wd_s1_reg    <= wd_s0_reg;
      wd_s2_reg    <= wd_s1_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Host strobe synchroniser and access decode

  logic [2:0] ds_sync_reg;
  logic       ds_prev_reg;
  logic       cs_reg;
  logic       a1_reg;
  logic       a0_reg;
  logic       rnw_reg;
  logic [15:0] wd_reg;

  // Only the agreed late stages are looked at; the first stage is metastable
  wire ds_agree   = (ds_sync_reg[1] == ds_sync_reg[2]);
  wire ds_low     = ~ds_sync_reg[2];
  wire ds_fall    = ds_agree && ds_low && ds_prev_reg;
  wire sel_cmd    = ~cs_reg && a1_reg && a0_reg;
  wire sel_cfg    = ~cs_reg && a1_reg && ~a0_reg;
  wire cmd_wr     = ds_fall && sel_cmd && ~rnw_reg;
  wire cfg_wr     = ds_fall && sel_cfg && ~rnw_reg;
  wire [3:0] opc  = wd_reg[`FCR_OPC_HI:`FCR_OPC_LO];
  wire [2:0] opr  = wd_reg[`FCR_OPR_HI:`FCR_OPR_LO];

  function automatic logic is_cmd(input logic [3:0] op, input logic [3:0] want);
    is_cmd = cmd_wr && (op == want);
  endfunction

  function automatic logic is_rst(input logic [2:0] od, input logic [2:0] want);
    is_rst = is_cmd(opc, `FCR_OP_RESET) && (od == want);
  endfunction

  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      ds_sync_reg <= 3'h7;
      ds_prev_reg <= 1'b1;
      cs_reg      <= 1'b1;
      a1_reg      <= 1'b0;
      a0_reg      <= 1'b0;
      rnw_reg     <= 1'b1;
      wd_reg      <= 16'h0000;
    end
    else if (ce_in)
    begin
      ds_sync_reg <= {ds_sync_reg[1:0], host_data_strobe_n_in};
      if (ds_agree)
        ds_prev_reg <= ds_sync_reg[2];
      // Address and data are sampled while the strobe is still high, so they
      // are settled by the time the synchronised falling edge is seen
      if (ds_agree && ~ds_low && pins_ok)
      begin
        cs_reg  <= cs_sync_reg[2];
        a1_reg  <= a1_sync_reg[2];
        a0_reg  <= a0_sync_reg[2];
        rnw_reg <= rnw_sync_reg[2];
        wd_reg  <= wd_s2_reg;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Reset scope decode

  wire rs_ba   = is_rst(opr, `FCR_RS_BA) || is_rst(opr, `FCR_RS_BOTH)
               || is_rst(opr, `FCR_RS_ALL);
  wire rs_ab   = is_rst(opr, `FCR_RS_AB) || is_rst(opr, `FCR_RS_BOTH)
               || is_rst(opr, `FCR_RS_ALL);
  wire rs_dma  = is_rst(opr, `FCR_RS_DMA) || is_rst(opr, `FCR_RS_ALL);
  wire rs_all  = is_rst(opr, `FCR_RS_ALL);

  ////////////////////////////////////////////////////////////////////////////
  // Configuration store

  fcr_cfg_if cfg ();
  logic [2:0] cfg_sel_reg;

  assign cfg.wr_en   = cfg_wr;
  assign cfg.wr_addr = cfg_sel_reg;
  assign cfg.wr_data = wd_reg;
  assign cfg.init    = rs_all;
  assign cfg.rd_addr = cfg_sel_reg;

  fcr_cfg_mem u_cfg
  (
    .core_clk_in (core_clk_in),
    .rst_in      (rst_in),
    .ce_in       (ce_in),
    .cfg         (cfg.mem)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Pointers, direction, format, flags

  logic [PTR_W-1:0] ab_rd_reg, ab_wr_reg, ab_rrd_reg;
  logic [PTR_W-1:0] ba_rd_reg, ba_wr_reg, ba_rwr_reg;
  logic             dir_reg, fmt_reg, wpe_reg, rpe_reg, val_reg, dmaclr_reg;

  wire [PTR_W-1:0] one = PTR_W'(1);

  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      ab_rd_reg   <= '0;
      ab_wr_reg   <= '0;
      ab_rrd_reg  <= '0;
      ba_rd_reg   <= '0;
      ba_wr_reg   <= '0;
      ba_rwr_reg  <= '0;
      cfg_sel_reg <= 3'h0;
      dir_reg     <= 1'b0;
      fmt_reg     <= 1'b0;
      wpe_reg     <= 1'b0;
      rpe_reg     <= 1'b0;
      val_reg     <= 1'b0;
      dmaclr_reg  <= 1'b1;
    end
    else if (ce_in)
    begin
      dmaclr_reg <= rs_dma;
      if (is_cmd(opc, `FCR_OP_SELCFG))
        cfg_sel_reg <= opr;
      if (rs_ab)
      begin
        ab_rd_reg  <= '0;
        ab_wr_reg  <= '0;
        ab_rrd_reg <= '0;
      end
      else
      begin
        if (is_cmd(opc, `FCR_OP_SAVE_RD))
          ab_rrd_reg <= ab_rd_reg;
        if (is_cmd(opc, `FCR_OP_REST_RD))
          ab_rd_reg <= ab_rrd_reg;
        else if (is_cmd(opc, `FCR_OP_INC_AB_RD) || ab_rd_step_in)
          ab_rd_reg <= ab_rd_reg + one;
      end
      if (rs_ba)
      begin
        ba_rd_reg  <= '0;
        ba_wr_reg  <= '0;
        ba_rwr_reg <= '0;
      end
      else
      begin
        if (is_cmd(opc, `FCR_OP_SAVE_WR))
          ba_rwr_reg <= ba_wr_reg;
        if (is_cmd(opc, `FCR_OP_REST_WR))
          ba_wr_reg <= ba_rwr_reg;
        else if (is_cmd(opc, `FCR_OP_INC_BA_WR) || ba_wr_step_in)
          ba_wr_reg <= ba_wr_reg + one;
      end
      if (is_cmd(opc, `FCR_OP_DMADIR) && cfg.periph_mode)
        dir_reg <= opr[0];
      if (is_cmd(opc, `FCR_OP_STFMT))
        fmt_reg <= opr[0];
      // A fresh error beats a clear in the same cycle
      if (wr_parity_err_in)
        wpe_reg <= 1'b1;
      else if (is_cmd(opc, `FCR_OP_CLR_WPE))
        wpe_reg <= 1'b0;
      if (rd_parity_err_in)
        rpe_reg <= 1'b1;
      else if (is_cmd(opc, `FCR_OP_CLR_RPE))
        rpe_reg <= 1'b0;
      if (odd_valid_set_in)
        val_reg <= 1'b1;
      else if (rs_ba || odd_valid_clr_in)
        val_reg <= 1'b0;
      // Opcodes 12 to 15 and reset operands 0, 5, 6 match nothing above
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status word

  wire [7:0] st_hi = {ba_aempty_in, ba_empty_in, ab_afull_in, ab_full_in,
                      fmt_reg, rpe_reg, wpe_reg, val_reg};
  wire [7:0] st_lo1 = {ba_afull_in, ba_full_in, ab_aempty_in, ab_empty_in,
                       dir_reg, 3'h0};
  wire [7:0] st_lo = fmt_reg ? st_lo1 : odd_byte_in;

  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
      host_rdata_out <= 16'h0000;
    else if (ce_in)
      host_rdata_out <= {st_hi, st_lo};
  end

  // is kept by the outside logic; the strobe synchroniser resets idle
  assign cfg_rdata_out   = cfg.rd_data;
  assign cfg_sel_out     = cfg_sel_reg;
  assign ab_rd_ptr_out   = ab_rd_reg;
  assign ba_wr_ptr_out   = ba_wr_reg;
  assign dma_dir_out     = dir_reg;
  assign dma_req_clr_out = dmaclr_reg;
  assign stat_fmt_out    = fmt_reg;
  assign odd_valid_out   = val_reg;
endmodule

// >>> sim/fcr_checker.sv
// Port-level checks for the command, reset and status block
`timescale 1ns/10ps
module fcr_checker
#(
  parameter int PTR_W = 10
)
(
  input wire logic             core_clk_in,
  input wire logic             rst_in,
  input wire logic             host_data_strobe_n_in,
  input wire logic [7:0]       odd_byte_in,
  input wire logic             ab_full_in,
  input wire logic             ab_afull_in,
  input wire logic             ba_empty_in,
  input wire logic             ba_aempty_in,
  input wire logic             wr_parity_err_in,
  input wire logic             ab_rd_step_in,
  input wire logic             ba_wr_step_in,
  input wire logic [15:0]      host_rdata_out,
  input wire logic [2:0]       cfg_sel_out,
  input wire logic [PTR_W-1:0] ab_rd_ptr_out,
  input wire logic [PTR_W-1:0] ba_wr_ptr_out,
  input wire logic             dma_dir_out,
  input wire logic             dma_req_clr_out,
  input wire logic             stat_fmt_out
);
  logic [3:0] idle_cnt;
  logic       quiet;
  // Strobe high this long means no command can still be in flight
  assign quiet = idle_cnt > 4'h8;
  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
      idle_cnt <= 4'h0;
    else if (!host_data_strobe_n_in)
      idle_cnt <= 4'h0;
    else if (idle_cnt != 4'hF)
      idle_cnt <= idle_cnt + 4'h1;
  end
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (rst_in);
  sequence s_wpe_set;
    ##[1:2] host_rdata_out[9];
  endsequence
  a_fmt0_low: assert property (!host_rdata_out[11] |->
    host_rdata_out[7:0] == $past(odd_byte_in))
    else $error("format 0 low byte wrong");
  a_fmt1_low: assert property (host_rdata_out[11] |->
    host_rdata_out[3:0] == {$past(dma_dir_out), 3'h0})
    else $error("format 1 low bits wrong");
  a_hi_flags: assert property (host_rdata_out[15:12] ==
    {$past(ba_aempty_in), $past(ba_empty_in), $past(ab_afull_in), $past(ab_full_in)})
    else $error("status flags wrong");
  a_wpe_set: assert property (wr_parity_err_in |-> s_wpe_set)
    else $error("write parity error not flagged");
  a_pe_keep: assert property (quiet |=>
    !$fell(host_rdata_out[9]) && !$fell(host_rdata_out[10]))
    else $error("parity error dropped without command");
  a_ab_step: assert property (quiet |=>
    ab_rd_ptr_out == $past(ab_rd_ptr_out) + $past(ab_rd_step_in))
    else $error("read pointer step wrong");
  a_ba_step: assert property (quiet |=>
    ba_wr_ptr_out == $past(ba_wr_ptr_out) + $past(ba_wr_step_in))
    else $error("write pointer step wrong");
  a_clr_pulse: assert property (dma_req_clr_out |=> !dma_req_clr_out)
    else $error("request clear longer than one cycle");
  a_ctl_hold: assert property (quiet |=>
    $stable(cfg_sel_out) && $stable(stat_fmt_out) && $stable(dma_dir_out))
    else $error("control state changed without command");
endmodule
bind fcr_top fcr_checker #(.PTR_W(PTR_W)) u_chk (.core_clk_in, .rst_in, .host_data_strobe_n_in,
  .odd_byte_in, .ab_full_in, .ab_afull_in, .ba_empty_in, .ba_aempty_in, .wr_parity_err_in,
  .ab_rd_step_in, .ba_wr_step_in, .host_rdata_out, .cfg_sel_out, .ab_rd_ptr_out, .ba_wr_ptr_out,
  .dma_dir_out, .dma_req_clr_out, .stat_fmt_out);

// >>> sim/fcr_host_model.sv
// Host processor model driving the command and status port
`timescale 1ns/10ps
module fcr_host_model
(
  input  wire logic        clk_in,
  input  wire logic [15:0] rdata_in,
  output logic             cs_n_out,
  output logic             addr_hi_out,
  output logic             addr_lo_out,
  output logic             rnw_out,
  output logic             ds_n_out,
  output logic [15:0]      wdata_out
);
  initial
  begin
    cs_n_out = 1'b1;
    {addr_hi_out, addr_lo_out} = 2'b00;
    rnw_out = 1'b1;
    ds_n_out = 1'b1;
    wdata_out = 16'hA5A5;
  end
  // Data flips once released so a stale word is never taken
  task automatic access(input logic [1:0] a, input logic rd, input logic [15:0] d,
                        input int gap, output logic [15:0] q);
    @(posedge clk_in);
    cs_n_out <= 1'b0;
    {addr_hi_out, addr_lo_out} <= a;
    rnw_out <= rd;
    wdata_out <= d;
    repeat (3) @(posedge clk_in);
    ds_n_out <= 1'b0;
    repeat (gap) @(posedge clk_in);
    q = rdata_in;
    ds_n_out <= 1'b1;
    repeat (4) @(posedge clk_in);
    cs_n_out <= 1'b1;
    wdata_out <= ~d;
  endtask
endmodule

// >>> sim/tb_top.sv
// Self-checking bench for the command, reset and status block
`timescale 1ns/10ps
module tb_top;
  localparam int PW = 4;
  logic          core_clk_in = 1'b0;
  logic          rst_in, ce_in, host_chip_select_n_in, host_addr_hi_in, host_addr_lo_in;
  logic          host_rnw_in, host_data_strobe_n_in, dma_dir_out, dma_req_clr_out;
  logic          stat_fmt_out, odd_valid_out;
  logic [15:0]   host_wdata_in, host_rdata_out, cfg_rdata_out, rq;
  logic [7:0]    odd_byte_in, flg;
  logic [5:0]    ev;
  logic [2:0]    cfg_sel_out;
  logic [PW-1:0] ab_rd_ptr_out, ba_wr_ptr_out;
  int            failures = 0, n_checks = 0, cyc = 0, clr_seen = 0, k;
  fcr_top #(.PTR_W(PW)) i_dut
  (
    .core_clk_in, .rst_in, .ce_in, .host_chip_select_n_in, .host_addr_hi_in, .host_addr_lo_in,
    .host_rnw_in, .host_data_strobe_n_in, .host_wdata_in, .odd_byte_in,
    .ab_empty_in(flg[0]), .ab_aempty_in(flg[1]), .ab_afull_in(flg[2]), .ab_full_in(flg[3]),
    .ba_empty_in(flg[4]), .ba_aempty_in(flg[5]), .ba_afull_in(flg[6]), .ba_full_in(flg[7]),
    .wr_parity_err_in(ev[0]), .rd_parity_err_in(ev[1]), .odd_valid_set_in(ev[2]),
    .odd_valid_clr_in(ev[3]), .ab_rd_step_in(ev[4]), .ba_wr_step_in(ev[5]),
    .host_rdata_out, .cfg_rdata_out, .cfg_sel_out, .ab_rd_ptr_out, .ba_wr_ptr_out,
    .dma_dir_out, .dma_req_clr_out, .stat_fmt_out, .odd_valid_out
  );
  fcr_host_model u_host
  (
    .clk_in(core_clk_in), .rdata_in(host_rdata_out), .cs_n_out(host_chip_select_n_in),
    .addr_hi_out(host_addr_hi_in), .addr_lo_out(host_addr_lo_in), .rnw_out(host_rnw_in),
    .ds_n_out(host_data_strobe_n_in), .wdata_out(host_wdata_in)
  );
  always #50 core_clk_in = ~core_clk_in;
  // Sampled mid-cycle so the one-cycle pulse is never missed
  always @(negedge core_clk_in)
    if (dma_req_clr_out === 1'b1)
      clr_seen++;
  always @(posedge core_clk_in)
  begin
    cyc <= cyc + 1;
    if (cyc == 5000)
    begin
      failures++;
      conclude();
    end
  end
  task automatic conclude();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    n_checks++;
    if (g !== e)
    begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  function automatic logic [15:0] st(input logic f, input logic [2:0] e, input logic d);
    st = {flg[5], flg[4], flg[2], flg[3], f, e,
          f ? {flg[6], flg[7], flg[1], flg[0], d, 3'h0} : odd_byte_in};
  endfunction
  // Ignored command bits are all ones to show they are not decoded
  task automatic cmd(input logic [3:0] op, input logic [2:0] a);
    u_host.access(2'b11, 1'b0, {4'hF, op, 5'h1F, a}, 8, rq);
  endtask
  task automatic rd_stat();
    u_host.access(2'b11, 1'b1, 16'h0000, 20, rq);
  endtask
  task automatic pulse(input int b, input int n);
    repeat (6) @(posedge core_clk_in);
    ev[b] <= 1'b1;
    repeat (n) @(posedge core_clk_in);
    ev[b] <= 1'b0;
    repeat (3) @(posedge core_clk_in);
  endtask
  task automatic t_reset();
    rd_stat();
    chk("stat", st(1'b0, 3'h0, 1'b0), rq);
    chk("cfg", 16'h0000, cfg_rdata_out);
    chk("state", 16'h0000,
        16'({ab_rd_ptr_out, ba_wr_ptr_out, stat_fmt_out, dma_dir_out}));
  endtask
  task automatic t_select();
    for (int i = 0; i < 8; i++)
    begin
      cmd(4'h1, 3'(i));
      chk("sel", 16'(i), 16'(cfg_sel_out));
      chk("cfg", (i == 4) ? 16'h6420 : 16'h0000, cfg_rdata_out);
    end
  endtask
  task automatic t_format();
    flg <= 8'h5A;
    odd_byte_in <= 8'hC3;
    cmd(4'h7, 3'h7);
    rd_stat();
    chk("stat1", st(1'b1, 3'h0, 1'b0), rq);
    flg <= 8'hA5;
    cmd(4'h7, 3'h6);
    rd_stat();
    chk("stat0", st(1'b0, 3'h0, 1'b0), rq);
  endtask
  task automatic t_dma();
    cmd(4'h6, 3'h1);
    chk("dir", 16'h0000, 16'(dma_dir_out));
    cmd(4'h1, 3'h5);
    u_host.access(2'b10, 1'b0, 16'h0400, 8, rq);
    cmd(4'h6, 3'h1);
    chk("dir", 16'h0001, 16'(dma_dir_out));
    cmd(4'h6, 3'h6);
    chk("dir", 16'h0000, 16'(dma_dir_out));
    cmd(4'h6, 3'h1);
  endtask
  task automatic t_all();
    cmd(4'h7, 3'h1);
    pulse(0, 1);
    cmd(4'h1, 3'h4);
    u_host.access(2'b10, 1'b0, 16'h1234, 8, rq);
    chk("cfg", 16'h1234, cfg_rdata_out);
    pulse(4, 1);
    k = clr_seen;
    cmd(4'h0, 3'h7);
    chk("cfg", 16'h6420, cfg_rdata_out);
    chk("keep", 16'h0003, 16'({ab_rd_ptr_out, stat_fmt_out, dma_dir_out}));
    chk("req", 16'(k + 1), 16'(clr_seen));
    rd_stat();
    chk("wpe", 16'h0001, 16'(rq[9]));
    cmd(4'h1, 3'h5);
    chk("cfg5", 16'h0000, cfg_rdata_out);
  endtask
  task automatic t_ptr();
    cmd(4'h8, 3'h0);
    cmd(4'h9, 3'h0);
    chk("ptr", 16'h0011, 16'({ab_rd_ptr_out, ba_wr_ptr_out}));
    pulse(4, 2);
    pulse(2, 1);
    cmd(4'h0, 3'h2);
    chk("ab", 16'h0101, 16'({odd_valid_out, ab_rd_ptr_out, ba_wr_ptr_out}));
    k = clr_seen;
    cmd(4'h0, 3'h0);
    cmd(4'h0, 3'h5);
    cmd(4'h0, 3'h6);
    for (int i = 12; i < 16; i++)
      cmd(4'(i), 3'h7);
    chk("nop", 16'h0701, 16'({stat_fmt_out, k == clr_seen, odd_valid_out, ab_rd_ptr_out,
        ba_wr_ptr_out}));
    cmd(4'h0, 3'h4);
    chk("req", 16'(k + 1), 16'(clr_seen));
    cmd(4'h0, 3'h1);
    chk("ba", 16'h0000, 16'({odd_valid_out, ba_wr_ptr_out}));
    pulse(4, 1);
    pulse(5, 1);
    pulse(2, 1);
    cmd(4'h0, 3'h3);
    chk("both", 16'h0000, 16'({odd_valid_out, ab_rd_ptr_out, ba_wr_ptr_out}));
  endtask
  task automatic t_reread();
    pulse(4, 2);
    cmd(4'h2, 3'h0);
    pulse(4, 3);
    cmd(4'h4, 3'h0);
    chk("reread", 16'h0002, 16'(ab_rd_ptr_out));
    pulse(5, 1);
    cmd(4'h3, 3'h0);
    pulse(5, 2);
    cmd(4'h5, 3'h0);
    chk("rewrite", 16'h0001, 16'(ba_wr_ptr_out));
  endtask
  task automatic t_parity();
    pulse(1, 1);
    repeat (20) @(posedge core_clk_in);
    rd_stat();
    chk("pe", 16'h0003, 16'(rq[10:9]));
    cmd(4'hA, 3'h0);
    rd_stat();
    chk("pe", 16'h0002, 16'(rq[10:9]));
    cmd(4'hB, 3'h0);
    rd_stat();
    chk("pe", 16'h0000, 16'(rq[10:9]));
  endtask
  initial
  begin
    rst_in = 1'b1;
    ce_in = 1'b1;
    flg = 8'h00;
    ev = 6'h00;
    odd_byte_in = 8'h00;
    repeat (3) @(posedge core_clk_in);
    rst_in <= 1'b0;
    t_reset();
    t_select();
    t_format();
    t_dma();
    t_all();
    t_ptr();
    t_reread();
    t_parity();
    conclude();
  end
endmodule
